/* File: src/par_address_translation_unit.sv */
// Address translation unit: virtual to physical relocation with limits.
//
// Summary of operation
// R1: Accept 16-bit virtual addresses covering a 64-kilobyte program space.
// R2: Produce an 18-bit or 22-bit physical address, chosen by parameter.
// R3: Top 8 kilobytes of physical space hold peripheral registers.
// R4: In the 22-bit variant memory accesses go to a separate memory bus.
// R5: While mapping, physical address is relocation base plus virtual address.
// R6: A page is 1 to 128 blocks of 64 bytes, 8192 bytes maximum.
// R7: Eight page relocation registers per set map the whole virtual range.
// R8: Each page may start on any 64-byte boundary in physical memory.
// R9: Accesses beyond a short page's allocated length are refused.
// R10: Every page relocates independently through its own constant.
// R11: Mapping lets the processor reach memory beyond the unmapped 56 kilobytes.
// R12: Virtual bits 15..13 pick the page; bits 12..0 add to base times 64.
// R13: A refused access is aborted and an error status is recorded.
// R14: Mode 00 selects kernel, 01 supervisor, 11 user register sets.
// R15: With mapping on, vector fetches use the kernel data-space set.
// R16: Instruction and data fetches may use separate relocation sets.
`timescale 1ns/10ps
`default_nettype none
module par_address_translation_unit #(
	parameter int PA_W     = 22,
	parameter bit SPLIT_ID = 1'b1
) (
	input  wire logic                          clock,
	input  wire logic                          rst,
	input  wire logic                          cfg_we,
	input  wire logic [1:0]                    cfg_mode,
	input  wire logic                          cfg_ispace,
	input  wire logic [par_pkg::PAGE_W-1:0]    cfg_page,
	input  wire logic [PA_W-7:0]               cfg_base,
	input  wire logic [par_pkg::LEN_W-1:0]     cfg_len,
	input  wire logic                          map_enable,
	input  wire logic                          req_valid,
	input  wire logic [par_pkg::VA_W-1:0]      req_vaddr,
	input  wire logic [1:0]                    req_mode,
	input  wire logic                          req_ispace,
	input  wire logic                          req_vector,
	input  wire logic                          err_clear,
	output logic                               rsp_valid,
	output logic [PA_W-1:0]                    rsp_paddr,
	output logic [par_pkg::IO_ADDR_W-1:0]      rsp_io_addr,
	output logic                               rsp_to_mem,
	output logic                               rsp_to_io,
	output logic                               rsp_abort,
	output logic                               err_flag,
	output logic [par_pkg::VA_W-1:0]           err_vaddr,
	output logic [1:0]                         err_mode,
	output par_pkg::par_cause_t                err_cause
);
	import par_pkg::*;

	localparam int BASE_W = PA_W - BLK_SHIFT;
	localparam int HI_W   = PA_W - OFFSET_W;

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	if (PA_W != PA_NARROW && PA_W != PA_WIDE) begin : g_bad_pa // R2
		$error("Physical width must be 18 or 22.");
	end

	// ****************************************************************
	// Set selection
	// ****************************************************************
	function automatic logic [1:0] mode_index(input logic [1:0] m);
		logic [1:0] r;
		r = 2'h0;
		case (m)
			MODE_SUPER: r = 2'h1;
			MODE_USER:  r = 2'h2;
			default:    r = 2'h0;
		endcase
		return r;
	endfunction

	logic [1:0]           eff_mode;
	logic                 eff_space;
	logic [IDX_W-1:0]     rd_index;
	logic [IDX_W-1:0]     wr_index;
	logic                 wr_ok;
	logic [BASE_W-1:0]    rd_base;
	logic [LEN_W-1:0]     rd_len;

	always_comb begin
		// Vector fetches always go through the kernel data-space set.
		eff_mode  = req_vector ? MODE_KERNEL : req_mode; // R15
		eff_space = req_vector ? 1'b0 : (req_ispace & SPLIT_ID); // R15 R16
		rd_index  = {mode_index(eff_mode), eff_space,
			req_vaddr[VA_W-1:OFFSET_W]}; // R12 R14
		wr_index  = {mode_index(cfg_mode), cfg_ispace & SPLIT_ID, cfg_page};
		// The reserved mode code has no set; writes to it are dropped.
		wr_ok     = cfg_we && cfg_mode != MODE_BAD; // R14
	end

	par_page_table #(
		.BASE_W   (BASE_W)
	) u_table (
		.clock    (clock),
		.rst      (rst),
		.wr_en    (wr_ok),
		.wr_index (wr_index),
		.wr_base  (cfg_base),
		.wr_len   (cfg_len),
		.rd_index (rd_index),
		.rd_base  (rd_base),
		.rd_len   (rd_len)
	); // R7 R10

	// ****************************************************************
	// Translation
	// ****************************************************************
	logic [PA_W-1:0]      reloc;
	logic [PA_W-1:0]      direct;
	logic [PA_W-1:0]      phys;
	logic                 len_fault;
	logic                 mode_fault;
	logic                 fault;
	logic                 is_io;

	always_comb begin
		// Base counts 64-byte blocks, so pages land on block boundaries.
		reloc = {rd_base, BLK_ZERO}
			+ PA_W'(req_vaddr[OFFSET_W-1:0]); // R5 R8 R12
		// Unmapped, the top virtual page still reaches the peripheral page.
		if (req_vaddr[VA_W-1:OFFSET_W] == IO_VPAGE) begin
			direct = {{HI_W{1'b1}}, req_vaddr[OFFSET_W-1:0]}; // R3
		end else begin
			direct = PA_W'(req_vaddr); // R1
		end
		phys       = map_enable ? reloc : direct; // R11
		len_fault  = map_enable
			&& req_vaddr[OFFSET_W-1:BLK_SHIFT] > rd_len; // R6 R9
		mode_fault = map_enable && !req_vector && req_mode == MODE_BAD;
		fault      = len_fault || mode_fault; // R13
		is_io      = &phys[PA_W-1:OFFSET_W]; // R3
	end

	// ****************************************************************
	// Response stage
	// ****************************************************************
	logic                 next_rsp_valid;
	logic [PA_W-1:0]      next_rsp_paddr;
	logic [IO_ADDR_W-1:0] next_rsp_io_addr;
	logic                 next_rsp_to_mem;
	logic                 next_rsp_to_io;
	logic                 next_rsp_abort;

	always_comb begin
		next_rsp_valid   = req_valid;
		next_rsp_paddr   = rsp_paddr;
		next_rsp_io_addr = rsp_io_addr;
		if (req_valid) begin
			next_rsp_paddr   = phys; // R2
			next_rsp_io_addr = phys[IO_ADDR_W-1:0];
		end
		// The peripheral bus carries only 18 bits, so memory has its own.
		next_rsp_to_io   = req_valid && !fault && is_io; // R4
		next_rsp_to_mem  = req_valid && !fault && !is_io; // R4
		next_rsp_abort   = req_valid && fault; // R13
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rsp_valid   <= 1'b0;
			rsp_paddr   <= '0;
			rsp_io_addr <= '0;
			rsp_to_mem  <= 1'b0;
			rsp_to_io   <= 1'b0;
			rsp_abort   <= 1'b0;
		end else begin
			rsp_valid   <= next_rsp_valid;
			rsp_paddr   <= next_rsp_paddr;
			rsp_io_addr <= next_rsp_io_addr;
			rsp_to_mem  <= next_rsp_to_mem;
			rsp_to_io   <= next_rsp_to_io;
			rsp_abort   <= next_rsp_abort;
		end
	end

	// ****************************************************************
	// Error status
	// ****************************************************************
	logic                 next_err_flag;
	logic [VA_W-1:0]      next_err_vaddr;
	logic [1:0]           next_err_mode;
	par_cause_t           next_err_cause;

	always_comb begin
		next_err_flag  = err_flag;
		next_err_vaddr = err_vaddr;
		next_err_mode  = err_mode;
		next_err_cause = err_cause;
		if (err_clear) begin
			next_err_flag  = 1'b0;
			next_err_cause = PAR_CAUSE_NONE;
		end
		// A fault in the clearing cycle wins so that no abort goes unseen.
		if (req_valid && fault) begin
			next_err_flag  = 1'b1; // R13
			next_err_vaddr = req_vaddr;
			next_err_mode  = eff_mode;
			next_err_cause = mode_fault ? PAR_CAUSE_MODE : PAR_CAUSE_LEN;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			err_flag  <= 1'b0;
			err_vaddr <= '0;
			err_mode  <= MODE_KERNEL;
			err_cause <= PAR_CAUSE_NONE;
		end else begin
			err_flag  <= next_err_flag;
			err_vaddr <= next_err_vaddr;
			err_mode  <= next_err_mode;
			err_cause <= next_err_cause;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	resp_one_cycle_a: assert property ( // R1
		req_valid |=> rsp_valid ##1 ($past(req_valid) || !rsp_valid))
		else $error("Response did not follow request by one cycle.");

	bus_select_exclusive_a: assert property ( // R4
		rsp_valid |-> $onehot({rsp_to_mem, rsp_to_io, rsp_abort}))
		else $error("Response must pick exactly one outcome.");

	unmapped_identity_a: assert property ( // R11
		req_valid && !map_enable && req_vaddr[15:13] != IO_VPAGE
		|=> rsp_to_mem && rsp_paddr == PA_W'($past(req_vaddr)))
		else $error("Unmapped low address not passed through.");

	unmapped_io_page_a: assert property ( // R3
		req_valid && !map_enable && req_vaddr[15:13] == IO_VPAGE
		|=> rsp_to_io && rsp_io_addr[12:0] == $past(req_vaddr[12:0]))
		else $error("Top virtual page did not reach peripheral page.");

	mapped_reloc_a: assert property ( // R5
		req_valid && map_enable && !fault
		|=> rsp_paddr == {$past(rd_base), BLK_ZERO}
			+ PA_W'($past(req_vaddr[12:0])))
		else $error("Mapped address is not base plus offset.");

	length_limit_a: assert property ( // R9
		req_valid && map_enable && req_vaddr[12:6] > rd_len
		|=> rsp_abort && !rsp_to_mem && !rsp_to_io)
		else $error("Access beyond page length was not aborted.");

	bad_mode_abort_a: assert property ( // R14
		req_valid && map_enable && !req_vector && req_mode == MODE_BAD
		|=> rsp_abort ##0 err_cause == PAR_CAUSE_MODE)
		else $error("Reserved mode access was not aborted.");

	vector_kernel_set_a: assert property ( // R15
		req_valid && req_vector |-> rd_index[5:3] == 3'h0)
		else $error("Vector fetch did not use kernel data set.");

	error_sticky_a: assert property ( // R13
		rsp_abort |-> err_flag ##1 (err_flag == (!$past(err_clear)
			|| ($past(req_valid) && $past(fault)))))
		else $error("Abort did not leave error status set.");

	error_set_wins_a: assert property ( // R13
		req_valid && fault && err_clear |=> err_flag
			&& err_vaddr == $past(req_vaddr))
		else $error("Fault lost in clearing cycle.");

	len_in_range_a: assert property ( // R6 R9
		req_valid && map_enable && !mode_fault
			&& req_vaddr[12:6] <= rd_len
		|=> !rsp_abort && rsp_valid)
		else $error("Access inside page length was aborted.");

	unmapped_no_abort_a: assert property ( // R11
		req_valid && !map_enable |=> !rsp_abort)
		else $error("Unmapped access was aborted.");

	paddr_hold_a: assert property ( // R2
		!req_valid |=> $stable(rsp_paddr) && $stable(rsp_io_addr))
		else $error("Physical address moved without a request.");

	io_addr_low_a: assert property ( // R4
		rsp_valid |-> rsp_io_addr == rsp_paddr[IO_ADDR_W-1:0])
		else $error("Peripheral address differs from physical address.");

	mem_below_io_a: assert property ( // R3
		rsp_to_mem |-> !(&rsp_paddr[PA_W-1:OFFSET_W]))
		else $error("Memory access landed in the peripheral region.");

	clear_drops_flag_a: assert property ( // R13
		err_clear && !(req_valid && fault)
		|=> !err_flag && err_cause == PAR_CAUSE_NONE)
		else $error("Error clear did not drop the status.");

	fault_record_a: assert property ( // R13
		req_valid && fault |=> err_flag && err_vaddr == $past(req_vaddr)
			&& err_mode == $past(eff_mode))
		else $error("Fault record does not match the refused access.");
endmodule // par_address_translation_unit
`default_nettype wire

/* File: src/par_page_table.sv */
// Bank of page relocation registers held in flip-flops.
`timescale 1ns/10ps
`default_nettype none
module par_page_table #(
	parameter int BASE_W = 16
) (
	input  wire logic                         clock,
	input  wire logic                         rst,
	input  wire logic                         wr_en,
	input  wire logic [par_pkg::IDX_W-1:0]    wr_index,
	input  wire logic [BASE_W-1:0]            wr_base,
	input  wire logic [par_pkg::LEN_W-1:0]    wr_len,
	input  wire logic [par_pkg::IDX_W-1:0]    rd_index,
	output logic      [BASE_W-1:0]            rd_base,
	output logic      [par_pkg::LEN_W-1:0]    rd_len
);
	import par_pkg::*;

	logic [BASE_W-1:0] base_q [ENTRIES];
	logic [LEN_W-1:0]  len_q  [ENTRIES];

	if (BASE_W < 1) begin : g_bad_width
		$error("Base width must be positive.");
	end

	for (genvar e = 0; e < ENTRIES; e++) begin : g_entry
		logic [BASE_W-1:0] next_base;
		logic [LEN_W-1:0]  next_len;

		always_comb begin
			next_base = base_q[e];
			next_len  = len_q[e];
			if (wr_en && wr_index == IDX_W'(e)) begin
				next_base = wr_base;
				next_len  = wr_len;
			end
		end

		// A full-length page with zero base makes every page of a fresh table map onto the first 8 kilobytes.
		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				base_q[e] <= '0;
				len_q[e]  <= LEN_RESET;
			end else begin
				base_q[e] <= next_base;
				len_q[e]  <= next_len;
			end
		end
	end

	always_comb begin
		rd_base = '0;
		rd_len  = '0;
		if (rd_index < IDX_W'(ENTRIES)) begin
			rd_base = base_q[rd_index];
			rd_len  = len_q[rd_index];
		end
	end
endmodule // par_page_table
`default_nettype wire

/* File: src/par_pkg.sv */
// Constants shared by the paged address relocation unit.
package par_pkg;
	// *****************************************************************
	// Address geometry
	// *****************************************************************
	localparam int VA_W       = 16;
	localparam int OFFSET_W   = 13;
	localparam int BLK_SHIFT  = 6;
	localparam int LEN_W      = 7;
	localparam int PAGE_W     = 3;
	localparam int PAGES      = 8;
	localparam int MODES      = 3;
	localparam int SPACES     = 2;
	localparam int ENTRIES    = MODES * SPACES * PAGES;
	localparam int IDX_W      = 6;
	localparam int PA_NARROW  = 18;
	localparam int PA_WIDE    = 22;
	localparam int IO_ADDR_W  = 18;

	// *****************************************************************
	// Field values and reset values
	// *****************************************************************
	localparam logic [PAGE_W-1:0] IO_VPAGE     = 3'h7;
	localparam logic [1:0]        MODE_KERNEL  = 2'h0;
	localparam logic [1:0]        MODE_SUPER   = 2'h1;
	localparam logic [1:0]        MODE_BAD     = 2'h2;
	localparam logic [1:0]        MODE_USER    = 2'h3;
	localparam logic [LEN_W-1:0]  LEN_RESET    = 7'h7F;
	localparam logic [BLK_SHIFT-1:0] BLK_ZERO  = 6'h00;

	typedef enum logic [1:0] {
		PAR_CAUSE_NONE = 2'b00,
		PAR_CAUSE_LEN  = 2'b01,
		PAR_CAUSE_MODE = 2'b10
	} par_cause_t;
endpackage

/* File: tb/par_core_model.sv */
// Processor-side source of virtual address requests.
`timescale 1ns/10ps
`default_nettype none
module par_core_model (
	input  wire logic                     clock,
	output logic                          req_valid,
	output logic [par_pkg::VA_W-1:0]      req_vaddr,
	output logic [1:0]                    req_mode,
	output logic                          req_ispace,
	output logic                          req_vector
);
	import par_pkg::*;
	initial begin
		req_valid = 1'b0;
		req_vaddr = 16'h0000;
		req_mode = MODE_KERNEL;
		req_ispace = 1'b0;
		req_vector = 1'b0;
	end
	// *************************************************************
	// Request driving
	// *************************************************************
	task automatic issue(input logic [VA_W-1:0] va, input logic [1:0] m,
		input logic i, input logic v);
		@(posedge clock);
		req_valid <= 1'b1;
		req_vaddr <= va;
		req_mode <= m;
		req_ispace <= i;
		req_vector <= v;
	endtask
	// Idle lines flip so that a stale request never looks fresh.
	task automatic rest();
		@(posedge clock);
		req_valid <= 1'b0;
		req_vaddr <= ~req_vaddr;
		req_mode <= ~req_mode;
		req_ispace <= ~req_ispace;
		req_vector <= ~req_vector;
	endtask
endmodule // par_core_model
`default_nettype wire

/* File: tb/test_paged_address_relocation.sv */
// Self-checking bench for the address translation unit.
`timescale 1ns/10ps
`default_nettype none
module test_paged_address_relocation;
	import par_pkg::*;
	logic clock, rst, cfg_we, cfg_ispace, map_enable, err_clear;
	logic [1:0] cfg_mode, req_mode, err_mode, em, e_em;
	logic [2:0] cfg_page;
	logic [15:0] cfg_base, req_vaddr, err_vaddr, e_va;
	logic [6:0] cfg_len;
	logic req_valid, req_ispace, req_vector, rsp_valid, rsp_to_mem;
	logic rsp_to_io, rsp_abort, err_flag, ab;
	logic e_valid, e_mem, e_io, e_ab, e_flag, e_pa_ok;
	logic [21:0] rsp_paddr, e_paddr;
	logic [17:0] rsp_io_addr;
	logic [23:0] r;
	par_cause_t err_cause, e_cause;
	logic [15:0] sh_base [4][2][8];
	logic [6:0] sh_len [4][2][8];
	int n_fail, samples_checked, cycles, seed;

	par_address_translation_unit #(.PA_W(22), .SPLIT_ID(1'b1)) DUT (
		.clock(clock), .rst(rst), .cfg_we(cfg_we), .cfg_mode(cfg_mode),
		.cfg_ispace(cfg_ispace), .cfg_page(cfg_page), .cfg_base(cfg_base),
		.cfg_len(cfg_len), .map_enable(map_enable), .req_valid(req_valid),
		.req_vaddr(req_vaddr), .req_mode(req_mode), .req_ispace(req_ispace),
		.req_vector(req_vector), .err_clear(err_clear),
		.rsp_valid(rsp_valid), .rsp_paddr(rsp_paddr),
		.rsp_io_addr(rsp_io_addr), .rsp_to_mem(rsp_to_mem),
		.rsp_to_io(rsp_to_io), .rsp_abort(rsp_abort), .err_flag(err_flag),
		.err_vaddr(err_vaddr), .err_mode(err_mode), .err_cause(err_cause));
	par_core_model core (.clock(clock), .req_valid(req_valid),
		.req_vaddr(req_vaddr), .req_mode(req_mode),
		.req_ispace(req_ispace), .req_vector(req_vector));

	// *************************************************************
	// Reference model
	// *************************************************************
	function automatic logic [23:0] predict(input logic [15:0] va,
		input logic [1:0] m, input logic s, input logic me);
		logic [21:0] pa;
		logic [1:0] c;
		c = PAR_CAUSE_NONE;
		if (!me) begin
			pa = (va[15:13] == IO_VPAGE) ? {9'h1FF, va[12:0]} : {6'h00, va};
		end else begin
			pa = {sh_base[m][s][va[15:13]], 6'h00} + {9'h000, va[12:0]};
			if (m == MODE_BAD) c = PAR_CAUSE_MODE;
			else if (va[12:6] > sh_len[m][s][va[15:13]]) c = PAR_CAUSE_LEN;
		end
		return {c, pa};
	endfunction
	// Entries are read before the same edge's write lands, as the unit does.
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			{e_valid, e_mem, e_io, e_ab, e_flag, e_pa_ok} <= 6'h01;
			{e_paddr, e_va, e_em} <= '0;
			e_cause <= PAR_CAUSE_NONE;
			for (int k = 0; k < 64; k++) begin
				sh_base[k/16][k[3]][k[2:0]] <= 16'h0000;
				sh_len[k/16][k[3]][k[2:0]] <= LEN_RESET;
			end
		end else begin
			e_valid <= req_valid;
			{e_mem, e_io, e_ab} <= 3'h0;
			if (err_clear) begin
				e_flag <= 1'b0;
				e_cause <= PAR_CAUSE_NONE;
			end
			if (req_valid) begin
				em = req_vector ? MODE_KERNEL : req_mode;
				r = predict(req_vaddr, em, req_ispace & ~req_vector, map_enable);
				ab = r[23:22] != 2'h0;
				e_paddr <= r[21:0];
				e_pa_ok <= r[23:22] != PAR_CAUSE_MODE;
				e_ab <= ab;
				e_io <= !ab && (&r[21:13]);
				e_mem <= !ab && !(&r[21:13]);
				if (ab) begin
					{e_flag, e_va, e_em} <= {1'b1, req_vaddr, em};
					e_cause <= par_cause_t'(r[23:22]);
				end
			end
			if (cfg_we && cfg_mode != MODE_BAD) begin
				sh_base[cfg_mode][cfg_ispace][cfg_page] <= cfg_base;
				sh_len[cfg_mode][cfg_ispace][cfg_page] <= cfg_len;
			end
		end
	end

	task automatic chk(input logic ok, input string what);
		samples_checked++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask
	always @(negedge clock) begin
		chk(rsp_valid === e_valid, "response strobe");
		chk(rsp_to_mem === e_mem && rsp_to_io === e_io, "route");
		chk(rsp_abort === e_ab, "abort");
		if (e_pa_ok) chk(rsp_paddr === e_paddr, "address");
		if (e_pa_ok) chk(rsp_io_addr === e_paddr[17:0], "io address");
		chk(err_flag === e_flag && err_cause === e_cause, "status");
		chk(err_vaddr === e_va && err_mode === e_em, "fault record");
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			close_out();
		end
	end
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// *************************************************************
	// Stimulus
	// *************************************************************
	task automatic cfg_write(input logic [1:0] m, input logic s,
		input logic [2:0] p, input logic [15:0] b, input logic [6:0] l);
		@(posedge clock);
		cfg_we <= 1'b1;
		{cfg_mode, cfg_ispace, cfg_page, cfg_base, cfg_len} <= {m, s, p, b, l};
	endtask
	initial begin
		{rst, cfg_we, cfg_mode, cfg_ispace, cfg_page} = 8'h80;
		{cfg_base, cfg_len, map_enable, err_clear} = '0;
		seed = $urandom(32'h6a6a_eeaf);
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		for (int p = 0; p < 8; p++)
			core.issue({p[2:0], 13'($urandom)}, 2'h3, 1'b0, 1'b0);
		for (int k = 0; k < 48; k++)
			cfg_write(k / 16 == 2 ? 2'h3 : 2'(k / 16), k[3], k[2:0],
				16'($urandom), 7'($urandom));
		cfg_write(2'h3, 1'b0, 3'h1, 16'h0100, 7'h00);
		cfg_write(2'h3, 1'b0, 3'h2, 16'hFFFF, 7'h7F);
		cfg_write(2'h0, 1'b0, 3'h0, 16'h0010, 7'h01);
		cfg_write(2'h2, 1'b0, 3'h0, 16'hFFFF, 7'h00);
		@(posedge clock);
		cfg_we <= 1'b0;
		map_enable <= 1'b1;
		core.issue(16'h2040, 2'h3, 1'b0, 1'b0);
		core.issue(16'h203F, 2'h3, 1'b0, 1'b0);
		core.issue(16'h5FFF, 2'h3, 1'b0, 1'b0);
		core.issue(16'h4010, 2'h3, 1'b0, 1'b0);
		core.issue(16'h0040, 2'h2, 1'b0, 1'b0);
		core.issue(16'h0040, 2'h2, 1'b0, 1'b1);
		core.issue(16'h0080, 2'h2, 1'b1, 1'b1);
		core.rest();
		err_clear <= 1'b1;
		core.rest();
		err_clear <= 1'b0;
		repeat (3000) begin
			if ($urandom_range(3) == 0) core.rest();
			else core.issue(16'($urandom), 2'($urandom), 1'($urandom),
				$urandom_range(7) == 0);
			map_enable <= $urandom_range(7) != 0;
			err_clear <= $urandom_range(15) == 0;
			cfg_we <= $urandom_range(7) == 0;
			{cfg_mode, cfg_ispace, cfg_page} <= 6'($urandom);
			{cfg_base, cfg_len} <= 23'($urandom);
		end
		core.rest();
		{rst, cfg_we, err_clear, map_enable} <= 4'h9;
		@(posedge clock);
		rst <= 1'b0;
		core.issue(16'h4123, 2'h0, 1'b0, 1'b0);
		core.rest();
		repeat (3) @(posedge clock);
		close_out();
	end
endmodule // test_paged_address_relocation
`default_nettype wire
